// ### thermal_throttle_cfg.svh
`ifndef THERMAL_THROTTLE_CFG_SVH
`define THERMAL_THROTTLE_CFG_SVH

// core clock rate in MHz (4 ns period)
`define TTC_CLK_MHZ       250
// hysteresis hold after the die cools, in ns
`define TTC_HYST_NS       10000
`define TTC_HYST_CYC      ((`TTC_HYST_NS * `TTC_CLK_MHZ) / 1000)
// frequency switch time, in ns (rounded up to whole cycles)
`define TTC_FSW_NS        5000
`define TTC_FSW_CYC       (((`TTC_FSW_NS * `TTC_CLK_MHZ) + 999) / 1000)
// dwell per voltage-id step, in ns (rounded up)
`define TTC_VSTEP_NS      1000
`define TTC_VSTEP_CYC     (((`TTC_VSTEP_NS * `TTC_CLK_MHZ) + 999) / 1000)
// longest clock-off interval under thermal control, in ns (rounded down)
`define TTC_OFF_MAX_NS    3000
`define TTC_OFF_MAX_CYC   ((`TTC_OFF_MAX_NS * `TTC_CLK_MHZ) / 1000)
// width of all down-counting timers
`define TTC_TMR_W         12
// cycles per eighth of a modulation period
`define TTC_SLOT_CYC      64
`define TTC_SLOT_W        6
// factory on-time in eighths (50 percent)
`define TTC_FACTORY_ON    3'h4
// clock duty modulation control fields
`define CDM_EN_BIT        4
`define CDM_DUTY_MSB      3
`define CDM_DUTY_LSB      1
`define CDM_RESET         64'h0000000000000000
// ratio and voltage select reset values
`define RVS_RATIO_RESET   6'h10
`define RVS_VID_RESET     6'h20

`endif

// ### thermal_throttle_pkg.sv
package thermal_throttle_pkg;

  // frequency / voltage sequencer of the second thermal monitor mode
  typedef enum logic [5:0] {
    ST_NORMAL    = 6'h01,
    ST_FREQ_DOWN = 6'h02,
    ST_VID_DOWN  = 6'h04,
    ST_LOW       = 6'h08,
    ST_VID_UP    = 6'h10,
    ST_FREQ_UP   = 6'h20
  } fv_state_t;

  typedef struct packed {
    logic       clk_en;
    logic [5:0] slot;
    logic [2:0] eighth;
  } duty_state_t;

  typedef struct packed {
    logic       hot_m;
    logic       hot_s;
    logic       hot_d;
    logic       irq_m;
    logic       irq_s;
    logic       irq_d;
    logic [11:0] hyst;
    fv_state_t  st;
    logic [11:0] tmr;
    logic [5:0] ratio;
    logic [5:0] voltage_id_code;
    logic [5:0] nom_ratio;
    logic [5:0] nom_vid;
    logic [5:0] req_ratio;
    logic [5:0] req_vid;
    logic       req_pend;
    logic       od_en;
    logic [2:0] od_duty;
    logic       ot_n;
    logic       ot_int;
    logic       irq_pend;
    logic       irq_del;
    logic       snoop_pend;
    logic       snoop_ack;
    logic       bus_block;
    logic       tcc_active;
    logic [63:0] cdm_rd;
  } ctl_state_t;

endpackage

// ### duty_if.sv
`timescale 1ns/1ps
interface duty_if;
  logic       active;
  logic [2:0] on_eighths;
  logic       clk_en;
  modport ctrl (output active, output on_eighths, input clk_en);
  modport modu (input active, input on_eighths, output clk_en);
endinterface

// ### duty_modulator.sv
`timescale 1ns/1ps
`include "thermal_throttle_cfg.svh"
module duty_modulator (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  duty_if.modu      dm
);
  thermal_throttle_pkg::duty_state_t r_ff;
  thermal_throttle_pkg::duty_state_t nxt_r;

  // eighths of a period: clocks run for the first on_eighths, then stop
  always_comb begin
    nxt_r = r_ff;
    if (!dm.active) begin
      nxt_r.slot   = '0;
      nxt_r.eighth = '0;
      nxt_r.clk_en = 1'b1;
    end else begin
      if (r_ff.slot == 6'(`TTC_SLOT_CYC - 1)) begin
        nxt_r.slot   = '0;
        nxt_r.eighth = r_ff.eighth + 3'h1;
      end else begin
        nxt_r.slot = r_ff.slot + 6'h01;
      end
      // off span is (8 - on) slots, at most 256 cycles for the factory duty
      nxt_r.clk_en = (nxt_r.eighth < dm.on_eighths);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r_ff <= '{clk_en: 1'b1, slot: 6'h00, eighth: 3'h0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign dm.clk_en = r_ff.clk_en;
endmodule

// ### thermal_throttle_control.sv
`timescale 1ns/1ps
`include "thermal_throttle_cfg.svh"
module thermal_throttle_control (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        die_hot_i,
  input  wire logic        tm1_enable_i,
  input  wire logic        tm2_enable_i,
  input  wire logic [5:0]  low_ratio_i,
  input  wire logic [5:0]  low_vid_i,
  input  wire logic        cdm_wr_i,
  input  wire logic [63:0] cdm_wdata_i,
  output logic      [63:0] cdm_rdata_o,
  input  wire logic        rvs_wr_i,
  input  wire logic [5:0]  rvs_ratio_i,
  input  wire logic [5:0]  rvs_vid_i,
  input  wire logic        ot_int_assert_en_i,
  input  wire logic        ot_int_deassert_en_i,
  input  wire logic        irq_edge_i,
  input  wire logic        snoop_req_i,
  output logic             snoop_ack_o,
  output logic             irq_pending_o,
  output logic             irq_deliver_o,
  output logic             core_clk_en_o,
  output logic             bus_block_o,
  output logic      [5:0]  bus_ratio_o,
  output logic      [5:0]  voltage_id_code_o,
  output logic             overtemp_indicator_n_o,
  output logic             overtemp_int_o,
  output logic             tcc_active_o
);
  thermal_throttle_pkg::ctl_state_t r_ff;
  thermal_throttle_pkg::ctl_state_t nxt_r;

  duty_if dm ();

  // thermal state seen through the synchronised sensor pin
  logic       engaged;
  logic       tcc1;

  // one-cycle strobes taken from the synchroniser tails
  logic       hot_rise;
  logic       hot_fall;
  logic       irq_rise;

  // on-demand on-time once the zero code is mapped
  logic [2:0] od_on;

  // one voltage-id table entry toward the target per call
  function automatic logic [5:0] step_toward(input logic [5:0] cur, input logic [5:0] tgt);
    logic [5:0] res;
    res = cur;
    if (cur < tgt) begin
      res = cur + 6'h01;
    end else if (cur > tgt) begin
      res = cur - 6'h01;
    end
    return res;
  endfunction

  // trip point lives in the sensor; no register exposes it
  assign engaged  = r_ff.hot_s | (r_ff.hyst != '0);
  assign tcc1     = tm1_enable_i & engaged;
  assign hot_rise = r_ff.hot_s & ~r_ff.hot_d;
  assign hot_fall = ~r_ff.hot_s & r_ff.hot_d;
  assign irq_rise = r_ff.irq_s & ~r_ff.irq_d;
  // code 000 has no on-time; it is run as the shortest on-time instead
  assign od_on    = (r_ff.od_duty == 3'h0) ? 3'h1 : r_ff.od_duty;

  // thermal control takes the modulator from on-demand mode
  assign dm.active     = tcc1 | r_ff.od_en;
  assign dm.on_eighths = tcc1 ? `TTC_FACTORY_ON : od_on;

  duty_modulator u_duty (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .dm        (dm)
  );

  always_comb begin
    nxt_r = r_ff;

    // pin synchronisers; only the second stage is looked at
    nxt_r.hot_m = die_hot_i;
    nxt_r.hot_s = r_ff.hot_m;
    nxt_r.hot_d = r_ff.hot_s;

    // interrupt pin gets the same two stages and an edge tap
    nxt_r.irq_m = irq_edge_i;
    nxt_r.irq_s = r_ff.irq_m;
    nxt_r.irq_d = r_ff.irq_s;

    // hysteresis restarts on every hot cycle, so short cool dips never release
    if (r_ff.hot_s) begin
      nxt_r.hyst = `TTC_TMR_W'(`TTC_HYST_CYC);
    end else if (r_ff.hyst != '0) begin
      nxt_r.hyst = r_ff.hyst - `TTC_TMR_W'(1);
    end

    // over-temperature pin and its edge interrupts ignore the mode enables
    nxt_r.ot_n   = ~r_ff.hot_s;
    nxt_r.ot_int = (hot_rise & ot_int_assert_en_i) | (hot_fall & ot_int_deassert_en_i);

    // clock duty modulation control: only bits 4:1 are kept
    if (cdm_wr_i) begin
      nxt_r.od_en   = cdm_wdata_i[`CDM_EN_BIT];
      nxt_r.od_duty = cdm_wdata_i[`CDM_DUTY_MSB:`CDM_DUTY_LSB];
    end

    // readback rebuilt from the kept bits; reserved bits read zero
    nxt_r.cdm_rd = '0;
    nxt_r.cdm_rd[`CDM_EN_BIT] = nxt_r.od_en;
    nxt_r.cdm_rd[`CDM_DUTY_MSB:`CDM_DUTY_LSB] = nxt_r.od_duty;

    // ratio and voltage select writes are parked while the sequencer is busy
    if (rvs_wr_i) begin
      nxt_r.req_ratio = rvs_ratio_i;
      nxt_r.req_vid   = rvs_vid_i;
      nxt_r.req_pend  = 1'b1;
    end

    // shared step timer: counts down and parks at zero
    if (r_ff.tmr != '0) begin
      nxt_r.tmr = r_ff.tmr - `TTC_TMR_W'(1);
    end

    // frequency / voltage sequencer
    // order: normal, freq down, vid down, low, vid up, freq up
    // a new nominal point waits until the sequencer is back at normal
    case (r_ff.st)
      // normal point: take parked ratio writes, watch for heat
      thermal_throttle_pkg::ST_NORMAL: begin
        if (tm2_enable_i && r_ff.hot_s) begin
          nxt_r.st        = thermal_throttle_pkg::ST_FREQ_DOWN;
          nxt_r.ratio     = low_ratio_i;
          nxt_r.tmr       = `TTC_TMR_W'(`TTC_FSW_CYC);
          nxt_r.bus_block = 1'b1;
        end else begin
          // parked write applies only here, never mid-event
          if (r_ff.req_pend) begin
            nxt_r.nom_ratio = r_ff.req_ratio;
            nxt_r.nom_vid   = r_ff.req_vid;
            nxt_r.req_pend  = rvs_wr_i;
          end
          nxt_r.ratio = nxt_r.nom_ratio;
          nxt_r.voltage_id_code   = nxt_r.nom_vid;
        end
      end

      // bus blocked while the multiplier settles at the low ratio
      thermal_throttle_pkg::ST_FREQ_DOWN: begin
        if (r_ff.tmr == '0) begin
          nxt_r.st        = thermal_throttle_pkg::ST_VID_DOWN;
          nxt_r.bus_block = 1'b0;
          nxt_r.tmr       = `TTC_TMR_W'(`TTC_VSTEP_CYC);
        end
      end

      // low ratio reached; walk the voltage id down
      thermal_throttle_pkg::ST_VID_DOWN: begin
        // core keeps running while the regulator follows each step
        if (r_ff.voltage_id_code == low_vid_i) begin
          nxt_r.st = thermal_throttle_pkg::ST_LOW;
        end else if (r_ff.tmr == '0) begin
          nxt_r.voltage_id_code = step_toward(r_ff.voltage_id_code, low_vid_i);
          nxt_r.tmr = `TTC_TMR_W'(`TTC_VSTEP_CYC);
        end
      end

      // hold the low point until cool and hysteresis both expire
      thermal_throttle_pkg::ST_LOW: begin
        if (!engaged) begin
          nxt_r.st  = thermal_throttle_pkg::ST_VID_UP;
          nxt_r.tmr = `TTC_TMR_W'(`TTC_VSTEP_CYC);
        end
      end

      // voltage id goes back first so the nominal ratio is safe
      thermal_throttle_pkg::ST_VID_UP: begin
        // heat returning mid-climb heads back down at the same low ratio
        if (r_ff.hot_s) begin
          nxt_r.st = thermal_throttle_pkg::ST_VID_DOWN;
        end else if (r_ff.voltage_id_code == r_ff.nom_vid) begin
          nxt_r.st        = thermal_throttle_pkg::ST_FREQ_UP;
          nxt_r.ratio     = r_ff.nom_ratio;
          nxt_r.tmr       = `TTC_TMR_W'(`TTC_FSW_CYC);
          nxt_r.bus_block = 1'b1;
        end else if (r_ff.tmr == '0) begin
          nxt_r.voltage_id_code = step_toward(r_ff.voltage_id_code, r_ff.nom_vid);
          nxt_r.tmr = `TTC_TMR_W'(`TTC_VSTEP_CYC);
        end
      end

      // nominal ratio restored behind a second bus block
      thermal_throttle_pkg::ST_FREQ_UP: begin
        if (r_ff.tmr == '0) begin
          nxt_r.st        = thermal_throttle_pkg::ST_NORMAL;
          nxt_r.bus_block = 1'b0;
        end
      end

      // unreachable codes fall back to the normal point
      default: begin
        nxt_r.st        = thermal_throttle_pkg::ST_NORMAL;
        nxt_r.bus_block = 1'b0;
      end
    endcase

    // any state off the normal point counts as thermal control
    nxt_r.tcc_active = tcc1 | (nxt_r.st != thermal_throttle_pkg::ST_NORMAL);

    // snoops are answered through clock modulation, but not during a switch
    nxt_r.snoop_ack = 1'b0;
    if (snoop_req_i) begin
      nxt_r.snoop_pend = 1'b1;
    end
    if (r_ff.snoop_pend && !r_ff.bus_block) begin
      nxt_r.snoop_ack  = 1'b1;
      nxt_r.snoop_pend = snoop_req_i;
    end

    // interrupts wait for clocks-on and an open bus; a new edge beats the clear
    nxt_r.irq_del = 1'b0;
    if (r_ff.irq_pend && dm.clk_en && !r_ff.bus_block) begin
      nxt_r.irq_del  = 1'b1;
      nxt_r.irq_pend = 1'b0;
    end
    if (irq_rise) begin
      nxt_r.irq_pend = 1'b1;
    end
  end

  // reset image of the whole state; one assignment avoids overlapping field writes
  localparam thermal_throttle_pkg::ctl_state_t ctl_reset = '{
    hot_m:      1'b0,
    hot_s:      1'b0,
    hot_d:      1'b0,
    irq_m:      1'b0,
    irq_s:      1'b0,
    irq_d:      1'b0,
    hyst:       12'h000,
    st:         thermal_throttle_pkg::ST_NORMAL,
    tmr:        12'h000,
    ratio:      `RVS_RATIO_RESET,
    voltage_id_code:        `RVS_VID_RESET,
    nom_ratio:  `RVS_RATIO_RESET,
    nom_vid:    `RVS_VID_RESET,
    req_ratio:  6'h00,
    req_vid:    6'h00,
    req_pend:   1'b0,
    od_en:      1'b0,
    od_duty:    3'h0,
    ot_n:       1'b1,
    ot_int:     1'b0,
    irq_pend:   1'b0,
    irq_del:    1'b0,
    snoop_pend: 1'b0,
    snoop_ack:  1'b0,
    bus_block:  1'b0,
    tcc_active: 1'b0,
    cdm_rd:     `CDM_RESET
  };

  // one register for all state, synchronous reset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r_ff <= ctl_reset;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs come straight from registers
  assign cdm_rdata_o            = r_ff.cdm_rd;
  assign snoop_ack_o            = r_ff.snoop_ack;
  assign irq_pending_o          = r_ff.irq_pend;
  assign irq_deliver_o          = r_ff.irq_del;
  assign core_clk_en_o          = dm.clk_en;
  assign bus_block_o            = r_ff.bus_block;
  assign bus_ratio_o            = r_ff.ratio;
  assign voltage_id_code_o      = r_ff.voltage_id_code;
  assign overtemp_indicator_n_o = r_ff.ot_n;
  assign overtemp_int_o         = r_ff.ot_int;
  assign tcc_active_o           = r_ff.tcc_active;
endmodule

// ### thermal_throttle_control_checker.sv
`timescale 1ns/1ps
module thermal_throttle_control_checker (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        die_hot_i,
  input wire logic        tm1_enable_i,
  input wire logic        cdm_wr_i,
  input wire logic [63:0] cdm_wdata_i,
  input wire logic [63:0] cdm_rdata_o,
  input wire logic        snoop_ack_o,
  input wire logic        irq_deliver_o,
  input wire logic        core_clk_en_o,
  input wire logic        bus_block_o,
  input wire logic [5:0]  bus_ratio_o,
  input wire logic [5:0]  voltage_id_code_o,
  input wire logic        overtemp_indicator_n_o,
  input wire logic        tcc_active_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [11:0] off_cnt_ff;
  logic [11:0] nxt_off_cnt;
  // length of the running clock-off interval, in cycles
  always_comb nxt_off_cnt = core_clk_en_o ? 12'h000 : off_cnt_ff + 12'h001;
  always_ff @(posedge sys_clk_i) off_cnt_ff <= sys_rst_i ? 12'h000 : nxt_off_cnt;
  logic [11:0] blk_len_ff;
  logic [11:0] nxt_blk_len;
  // cycles the bus has stayed blocked; a whole switch is too long for a delay range
  always_comb nxt_blk_len = bus_block_o ? blk_len_ff + 12'h001 : 12'h000;
  always_ff @(posedge sys_clk_i) blk_len_ff <= sys_rst_i ? 12'h000 : nxt_blk_len;
  sequence s_block_hold;
    bus_block_o [*8];
  endsequence
  property p_ot_follow;
    die_hot_i [*8] |-> !overtemp_indicator_n_o;
  endproperty
  property p_off_max;
    tcc_active_o |-> off_cnt_ff <= 12'h2ee;
  endproperty
  property p_tcc_hot;
    tm1_enable_i && !overtemp_indicator_n_o |-> ##[0:2] tcc_active_o;
  endproperty
  property p_block_len;
    $rose(bus_block_o) |-> s_block_hold;
  endproperty
  property p_block_end;
    $fell(bus_block_o) |-> blk_len_ff >= 12'h4a6 && blk_len_ff <= 12'h514;
  endproperty
  property p_block_max;
    bus_block_o |-> blk_len_ff <= 12'h514;
  endproperty
  property p_block_quiet;
    bus_block_o && $past(bus_block_o, 2) |-> !snoop_ack_o && !irq_deliver_o;
  endproperty
  property p_vid_step;
    tcc_active_o && $changed(voltage_id_code_o) |-> voltage_id_code_o == $past(voltage_id_code_o) + 6'h01
      || voltage_id_code_o == $past(voltage_id_code_o) - 6'h01;
  endproperty
  property p_ratio_sw;
    tcc_active_o && $changed(bus_ratio_o) |-> bus_block_o;
  endproperty
  property p_rdata;
    cdm_wr_i |=> cdm_rdata_o == ($past(cdm_wdata_i) & 64'h000000000000001e);
  endproperty
  property p_od_start;
    cdm_wr_i && cdm_wdata_i[4] && cdm_wdata_i[3:1] == 3'h1 && !tcc_active_o |-> ##[1:200] !core_clk_en_o;
  endproperty
  a_ot_follow: assert property (p_ot_follow)
    else $error("overtemp output not low while hot");
  a_off_max: assert property (p_off_max)
    else $error("clock off interval too long");
  a_tcc_hot: assert property (p_tcc_hot)
    else $error("thermal control idle while overtemp");
  a_block_len: assert property (p_block_len)
    else $error("frequency switch length wrong");
  a_block_end: assert property (p_block_end)
    else $error("frequency switch ended outside its window");
  a_block_max: assert property (p_block_max)
    else $error("frequency switch still blocking past its limit");
  a_block_quiet: assert property (p_block_quiet)
    else $error("bus activity during frequency switch");
  a_vid_step: assert property (p_vid_step)
    else $error("voltage id moved more than one entry");
  a_ratio_sw: assert property (p_ratio_sw)
    else $error("ratio changed outside a switch");
  a_rdata: assert property (p_rdata)
    else $error("duty control readback wrong");
  a_od_start: assert property (p_od_start)
    else $error("on-demand modulation did not start");
endmodule
bind thermal_throttle_control thermal_throttle_control_checker i_chk (.*);

// ### vreg_model.sv
`timescale 1ns/1ps
// regulator tracks the voltage id; a jump wider than one entry is flagged
module vreg_model (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [5:0] vid_i,
  output logic            step_err_o
);
  logic [5:0] vout_ff;
  always_ff @(posedge sys_clk_i) begin
    vout_ff <= vid_i;
    if (sys_rst_i) step_err_o <= 1'b0;
    else if (vid_i != vout_ff && vid_i != vout_ff + 6'h01 && vid_i != vout_ff - 6'h01) step_err_o <= 1'b1;
  end
endmodule

// ### thermal_throttle_control_tb_top.sv
`timescale 1ns/1ps
module thermal_throttle_control_tb_top;
  logic sys_clk_i, sys_rst_i, die_hot_i, tm1_enable_i, tm2_enable_i, cdm_wr_i, rvs_wr_i, snoop_req_i;
  logic ot_int_assert_en_i, ot_int_deassert_en_i, irq_edge_i, step_err;
  logic [5:0] low_ratio_i, low_vid_i, rvs_ratio_i, rvs_vid_i, bus_ratio_o, voltage_id_code_o;
  logic [63:0] cdm_wdata_i, cdm_rdata_o;
  logic snoop_ack_o, irq_pending_o, irq_deliver_o, core_clk_en_o, bus_block_o;
  logic overtemp_indicator_n_o, overtemp_int_o, tcc_active_o;
  int fail_count, cmp_count, n, c, ot_ints;
  thermal_throttle_control i_dut (.*);
  vreg_model i_vreg (.sys_clk_i, .sys_rst_i, .vid_i(voltage_id_code_o), .step_err_o(step_err));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // over-temp interrupt pulses seen
  always @(negedge sys_clk_i) if (overtemp_int_o === 1'b1) ot_ints++;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for a level; running out is a mismatch and ends the run
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(64'(s), 64'(v));
    if (s !== v) end_sim();
  endtask
  task automatic wr_cdm(input logic [63:0] d);
    @(posedge sys_clk_i);
    cdm_wr_i <= 1'b1;
    cdm_wdata_i <= d;
    @(posedge sys_clk_i);
    cdm_wr_i <= 1'b0;
  endtask
  task automatic pulse_snoop();
    @(posedge sys_clk_i);
    snoop_req_i <= 1'b1;
    @(posedge sys_clk_i);
    snoop_req_i <= 1'b0;
  endtask
  // clock-on cycles over one full modulation period
  task automatic on_cnt();
    c = 0;
    repeat (512) begin
      @(negedge sys_clk_i);
      if (core_clk_en_o === 1'b1) c++;
    end
  endtask
  task automatic t_reset();
    @(negedge sys_clk_i);
    chk(cdm_rdata_o, 64'h0);
    chk(64'(bus_ratio_o), 64'h10);
    chk(64'(voltage_id_code_o), 64'h20);
    chk(64'(overtemp_indicator_n_o), 64'h1);
    chk(64'(core_clk_en_o), 64'h1);
    $display("test reset done");
  endtask
  // duty codes 1 to 7, reserved bits 63:5 set on the write
  task automatic t_od();
    for (int d = 1; d < 8; d++) begin
      wr_cdm(64'hffffffffffffffe0 | 64'h10 | 64'(d << 1));
      @(negedge sys_clk_i);
      chk(cdm_rdata_o, 64'h10 | 64'(d << 1));
      repeat (600) @(negedge sys_clk_i);
      on_cnt();
      chk(64'(c), 64'(d * 64));
    end
    wr_cdm(64'h0);
    wt(core_clk_en_o, 1'b1, 4);
    on_cnt();
    chk(64'(c), 64'd512);
    $display("test on-demand done");
  endtask
  task automatic t_tm1();
    @(posedge sys_clk_i);
    tm1_enable_i <= 1'b1;
    ot_int_assert_en_i <= 1'b1;
    @(posedge sys_clk_i);
    die_hot_i <= 1'b1;
    wt(overtemp_indicator_n_o, 1'b0, 8);
    wt(tcc_active_o, 1'b1, 4);
    // on-demand asked for while thermal control already holds the modulator
    wr_cdm(64'h12);
    repeat (600) @(negedge sys_clk_i);
    on_cnt();
    chk(64'(c), 64'd256);
    pulse_snoop();
    wt(snoop_ack_o, 1'b1, 4);
    @(posedge sys_clk_i);
    irq_edge_i <= 1'b1;
    wt(irq_deliver_o, 1'b1, 600);
    chk(64'(irq_pending_o), 64'h0);
    @(posedge sys_clk_i);
    irq_edge_i <= 1'b0;
    die_hot_i <= 1'b0;
    ot_int_deassert_en_i <= 1'b1;
    wt(overtemp_indicator_n_o, 1'b1, 8);
    repeat (2000) @(negedge sys_clk_i);
    chk(64'(tcc_active_o), 64'h1);
    wt(tcc_active_o, 1'b0, 700);
    chk(64'(ot_ints), 64'h2);
    wr_cdm(64'h0);
    tm1_enable_i <= 1'b0;
    $display("test first mode done");
  endtask
  task automatic t_tm2();
    @(posedge sys_clk_i);
    tm2_enable_i <= 1'b1;
    low_ratio_i <= 6'h08;
    low_vid_i <= 6'h1c;
    die_hot_i <= 1'b1;
    wt(bus_block_o, 1'b1, 10);
    chk(64'(bus_ratio_o), 64'h08);
    chk(64'(voltage_id_code_o), 64'h20);
    pulse_snoop();
    @(posedge sys_clk_i);
    irq_edge_i <= 1'b1;
    repeat (8) @(negedge sys_clk_i);
    chk(64'(irq_pending_o), 64'h1);
    chk(64'(irq_deliver_o), 64'h0);
    wt(bus_block_o, 1'b0, 1300);
    wt(snoop_ack_o, 1'b1, 4);
    chk(64'(irq_deliver_o), 64'h1);
    n = 0;
    while (voltage_id_code_o !== 6'h1c && n < 1200) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(64'(voltage_id_code_o), 64'h1c);
    @(posedge sys_clk_i);
    rvs_wr_i <= 1'b1;
    rvs_ratio_i <= 6'h0c;
    rvs_vid_i <= 6'h20;
    @(posedge sys_clk_i);
    rvs_wr_i <= 1'b0;
    die_hot_i <= 1'b0;
    irq_edge_i <= 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk(64'(bus_ratio_o), 64'h08);
    wt(bus_block_o, 1'b1, 4000);
    chk(64'(voltage_id_code_o), 64'h20);
    wt(bus_block_o, 1'b0, 1300);
    repeat (4) @(negedge sys_clk_i);
    chk(64'(bus_ratio_o), 64'h0c);
    chk(64'(step_err), 64'h0);
    $display("test second mode done");
  endtask
  initial begin
    fail_count = 0;
    cmp_count = 0;
    ot_ints = 0;
    sys_rst_i = 1'b1;
    {die_hot_i, tm1_enable_i, tm2_enable_i, cdm_wr_i, rvs_wr_i, snoop_req_i} = 6'h00;
    {ot_int_assert_en_i, ot_int_deassert_en_i, irq_edge_i} = 3'h0;
    {low_ratio_i, low_vid_i, rvs_ratio_i, rvs_vid_i} = 24'h000000;
    cdm_wdata_i = 64'h0;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_od();
    t_tm1();
    t_tm2();
    end_sim();
  end
endmodule
